// File: shared/pmta_consts.vh
/*
 Offsets, field positions and reset values for the program memory
 table-access block. Assumes a 32-bit APB bus with word-aligned registers.
*/
`ifndef PMTA_CONSTS_VH
`define PMTA_CONSTS_VH

// Register byte offsets
`define PMTA_OFS_CTRL     8'h00
`define PMTA_OFS_LATCH    8'h04
`define PMTA_OFS_PTR_LOW  8'h08
`define PMTA_OFS_PTR_HIGH 8'h0c
`define PMTA_OFS_PTR_UP   8'h10
`define PMTA_OFS_CMD      8'h14
`define PMTA_OFS_STATUS   8'h18

// Control register fields
`define PMTA_CTRL_MEMSEL  7
`define PMTA_CTRL_CFGSEL  6
`define PMTA_CTRL_ERASE   4
`define PMTA_CTRL_ABORT   3
`define PMTA_CTRL_UNLOCK  2
`define PMTA_CTRL_START   1

// Command register fields
`define PMTA_CMD_GO       0
`define PMTA_CMD_STORE    1
`define PMTA_CMD_MODE_LO  2
`define PMTA_CMD_MODE_HI  3

// Pointer update modes
`define PMTA_MODE_PLAIN   2'h0
`define PMTA_MODE_POSTINC 2'h1
`define PMTA_MODE_POSTDEC 2'h2
`define PMTA_MODE_PREINC  2'h3

// Status register fields
`define PMTA_STAT_BUSY    0
`define PMTA_STAT_DONE    1

// Reset values and sizes
`define PMTA_CTRL_RESET   8'h00
`define PMTA_HOLD_RESET   8'hff
`define PMTA_PTR_BITS     22
`define PMTA_LIN_BITS     21
`define PMTA_ERASE_LSBS   6

`endif

// File: src/pmta_table_access.v
/*
 Program memory table-access path: table pointer, table latch, write
 holding registers and the flash access control register, as an APB slave.
 Assumes a flash array on the same clock that answers a byte read with a
 one-cycle valid pulse and ends a program or erase with a done pulse.
*/
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "pmta_consts.vh"

module pmta_table_access #(
   parameter HOLD_BITS = 3
) (
   // Clock and reset
   input  wire                         pclk,
   input  wire                         presetn,
   // APB slave
   input  wire                         psel,
   input  wire                         penable,
   input  wire                         pwrite,
   input  wire [7:0]                   paddr,
   input  wire [31:0]                  pwdata,
   output reg  [31:0]                  prdata,
   output wire                         pready,
   output wire                         pslverr,
   // Flash byte read
   output reg                          fl_rd_req,
   output reg  [`PMTA_PTR_BITS-1:0]    fl_rd_addr,
   input  wire [7:0]                   fl_rd_data,
   input  wire                         fl_rd_valid,
   // Flash program and erase; space select of the byte read address
   output reg                          fl_prog_start,
   output reg                          fl_erase_start,
   output reg  [`PMTA_PTR_BITS-1:0]    fl_op_addr,
   output wire [8*(1<<HOLD_BITS)-1:0]  fl_hold_data,
   output wire                         fl_cfg_space,
   input  wire                         fl_op_done,
   // Completion flag
   output wire                         nvm_done_flag
);

   localparam DEPTH    = 1 << HOLD_BITS;
   localparam ST_IDLE  = 3'b001;
   localparam ST_RDW   = 3'b010;
   localparam ST_PROG  = 3'b100;

   reg  [2:0]                 state_q;
   reg  [`PMTA_PTR_BITS-1:0]  ptr_q;
   reg  [7:0]                 latch_q;
   reg  [7:0]                 ctrl_q;
   reg  [1:0]                 mode_q;
   reg                        done_q;
   reg  [7:0]                 hold_q [0:DEPTH-1];
   reg  [`PMTA_PTR_BITS-1:0]  ptr_d;
   reg  [`PMTA_PTR_BITS-1:0]  use_addr;
   reg  [31:0]                rd_word;
   reg                        addr_ok;
   wire                       access;
   wire                       wr_en;
   wire                       cmd_hit;
   wire                       cmd_go;
   wire                       op_ok;
   integer                    i;

   // Step the 21-bit linear part, top bit held
   function [`PMTA_PTR_BITS-1:0] ptr_step;
      input [`PMTA_PTR_BITS-1:0] p;
      input                      down;
      begin
         if (down) begin
            ptr_step = {p[`PMTA_PTR_BITS-1],
                        p[`PMTA_LIN_BITS-1:0] - 21'h000001};
         end else begin
            ptr_step = {p[`PMTA_PTR_BITS-1],
                        p[`PMTA_LIN_BITS-1:0] + 21'h000001};
         end
      end
   endfunction

   // Pointer after a completed transfer
   function [`PMTA_PTR_BITS-1:0] ptr_after;
      input [`PMTA_PTR_BITS-1:0] p;
      input [1:0]                m;
      begin
         case (m)
            `PMTA_MODE_POSTINC: ptr_after = ptr_step(p, 1'b0);
            `PMTA_MODE_POSTDEC: ptr_after = ptr_step(p, 1'b1);
            default:            ptr_after = p;
         endcase
      end
   endfunction

   assign access  = psel && penable;
   assign cmd_hit = (paddr == `PMTA_OFS_CMD);
   // Table commands stall the bus while a transfer or long write runs
   assign pready  = !(psel && cmd_hit && (state_q != ST_IDLE));
   assign pslverr = access && !addr_ok;
   assign wr_en   = access && pwrite && pready && addr_ok;
   assign cmd_go  = wr_en && cmd_hit && pwdata[`PMTA_CMD_GO];
   assign op_ok   = ctrl_q[`PMTA_CTRL_UNLOCK] &&
                    ctrl_q[`PMTA_CTRL_MEMSEL];
   assign nvm_done_flag = done_q;
   assign fl_cfg_space  = fl_rd_addr[`PMTA_PTR_BITS-1];

   // Holding block exported to the flash programmer
   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_hold
         assign fl_hold_data[8*g +: 8] = hold_q[g];
      end
   endgenerate

   // Address decode and read data
   always @* begin
      addr_ok = 1'b1;
      rd_word = 32'h00000000;
      case (paddr)
         `PMTA_OFS_CTRL:     rd_word[7:0] = ctrl_q;
         `PMTA_OFS_LATCH:    rd_word[7:0] = latch_q;
         `PMTA_OFS_PTR_LOW:  rd_word[7:0] = ptr_q[7:0];
         `PMTA_OFS_PTR_HIGH: rd_word[7:0] = ptr_q[15:8];
         `PMTA_OFS_PTR_UP:   rd_word[5:0] = ptr_q[21:16];
         `PMTA_OFS_CMD:      rd_word[3:0] = {mode_q, 2'h0};
         `PMTA_OFS_STATUS: begin
            rd_word[`PMTA_STAT_BUSY] = (state_q != ST_IDLE);
            rd_word[`PMTA_STAT_DONE] = done_q;
         end
         default:            addr_ok = 1'b0;
      endcase
   end

   // Address used by the transfer about to start
   always @* begin
      if (pwdata[`PMTA_CMD_MODE_HI:`PMTA_CMD_MODE_LO] == `PMTA_MODE_PREINC) begin
         use_addr = ptr_step(ptr_q, 1'b0);
      end else begin
         use_addr = ptr_q;
      end
   end

   // Pointer next value
   always @* begin
      ptr_d = ptr_q;
      if (wr_en && paddr == `PMTA_OFS_PTR_LOW) begin
         ptr_d[7:0] = pwdata[7:0];
      end
      if (wr_en && paddr == `PMTA_OFS_PTR_HIGH) begin
         ptr_d[15:8] = pwdata[7:0];
      end
      if (wr_en && paddr == `PMTA_OFS_PTR_UP) begin
         ptr_d[21:16] = pwdata[5:0];
      end
      if (cmd_go && state_q == ST_IDLE) begin
         if (pwdata[`PMTA_CMD_STORE]) begin
            ptr_d = ptr_after(use_addr,
               pwdata[`PMTA_CMD_MODE_HI:`PMTA_CMD_MODE_LO]);
         end else begin
            ptr_d = use_addr;
         end
      end
      if (state_q == ST_RDW && fl_rd_valid) begin
         ptr_d = ptr_after(ptr_q, mode_q);
      end
   end

   // Main sequencer and registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q        <= ST_IDLE;
         ptr_q          <= 22'h000000;
         latch_q        <= 8'h00;
         ctrl_q         <= `PMTA_CTRL_RESET;
         mode_q         <= 2'h0;
         done_q         <= 1'b0;
         fl_rd_req      <= 1'b0;
         fl_rd_addr     <= 22'h000000;
         fl_prog_start  <= 1'b0;
         fl_erase_start <= 1'b0;
         fl_op_addr     <= 22'h000000;
         prdata         <= 32'h00000000;
         for (i = 0; i < DEPTH; i = i + 1) begin
            hold_q[i] <= `PMTA_HOLD_RESET;
         end
      end else begin
         ptr_q          <= ptr_d;
         fl_rd_req      <= 1'b0;
         fl_prog_start  <= 1'b0;
         fl_erase_start <= 1'b0;
         if (access && !pwrite && pready) begin
            prdata <= rd_word;
         end
         if (wr_en && paddr == `PMTA_OFS_LATCH) begin
            latch_q <= pwdata[7:0];
         end
         if (wr_en && paddr == `PMTA_OFS_STATUS &&
             pwdata[`PMTA_STAT_DONE]) begin
            done_q <= 1'b0;
         end
         if (wr_en && paddr == `PMTA_OFS_CTRL) begin
            ctrl_q[`PMTA_CTRL_MEMSEL] <= pwdata[`PMTA_CTRL_MEMSEL];
            ctrl_q[`PMTA_CTRL_CFGSEL] <= pwdata[`PMTA_CTRL_CFGSEL];
            ctrl_q[`PMTA_CTRL_ERASE]  <= pwdata[`PMTA_CTRL_ERASE];
            ctrl_q[`PMTA_CTRL_ABORT]  <= pwdata[`PMTA_CTRL_ABORT];
            ctrl_q[`PMTA_CTRL_UNLOCK] <= pwdata[`PMTA_CTRL_UNLOCK];
            // Start can only be set, and only when unlocked and idle
            if (pwdata[`PMTA_CTRL_START] && op_ok &&
                state_q == ST_IDLE) begin
               ctrl_q[`PMTA_CTRL_START] <= 1'b1;
               ctrl_q[`PMTA_CTRL_ABORT] <= 1'b1;
               state_q    <= ST_PROG;
               if (pwdata[`PMTA_CTRL_ERASE]) begin
                  fl_erase_start <= 1'b1;
                  fl_op_addr <= {ptr_q[21:`PMTA_ERASE_LSBS],
                                 6'h00};
               end else begin
                  fl_prog_start <= 1'b1;
                  fl_op_addr <= {ptr_q[21:HOLD_BITS],
                                 {HOLD_BITS{1'b0}}};
               end
            end
         end
         case (state_q)
            ST_IDLE: begin
               if (cmd_go) begin
                  mode_q <= pwdata[`PMTA_CMD_MODE_HI:`PMTA_CMD_MODE_LO];
                  if (pwdata[`PMTA_CMD_STORE]) begin
                     hold_q[use_addr[HOLD_BITS-1:0]] <= latch_q;
                  end else begin
                     fl_rd_req  <= 1'b1;
                     fl_rd_addr <= use_addr;
                     state_q    <= ST_RDW;
                  end
               end
            end
            ST_RDW: begin
               if (fl_rd_valid) begin
                  latch_q <= fl_rd_data;
                  state_q <= ST_IDLE;
               end
            end
            ST_PROG: begin
               if (fl_op_done) begin
                  ctrl_q[`PMTA_CTRL_START] <= 1'b0;
                  ctrl_q[`PMTA_CTRL_ABORT] <= 1'b0;
                  done_q  <= 1'b1;
                  state_q <= ST_IDLE;
                  for (i = 0; i < DEPTH; i = i + 1) begin
                     hold_q[i] <= `PMTA_HOLD_RESET;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // pmta_table_access

// File: bench/pmta_table_access_props.sv
/* Port assertions for the table-access block.
   Bound to pmta_table_access; sees its ports only. */
`timescale 1ns/10ps
module pmta_table_access_props #(
   parameter HOLD_BITS = 3
) (
   // Clock and reset
   input wire                       pclk,
   input wire                       presetn,
   // APB
   input wire                       psel,
   input wire                       penable,
   input wire                       pwrite,
   input wire                       pready,
   input wire [7:0]                 paddr,
   input wire [31:0]                pwdata,
   // Flash side
   input wire                       fl_rd_req,
   input wire [21:0]                fl_rd_addr,
   input wire                       fl_cfg_space,
   input wire                       fl_prog_start,
   input wire                       fl_erase_start,
   input wire [21:0]                fl_op_addr,
   input wire [8*(1<<HOLD_BITS)-1:0] fl_hold_data,
   input wire                       fl_op_done,
   input wire                       nvm_done_flag
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_done = psel & penable & pready & pwrite;

   a_rd_pulse: assert property (fl_rd_req |=> !fl_rd_req)
      else $error("read request too long");
   a_rd_cause: assert property (fl_rd_req |-> $past(wr_done &&
      paddr == 8'h14 && pwdata[1:0] == 2'b01)) else $error("stray read");
   a_cfg_space: assert property (fl_rd_req |->
      fl_cfg_space == fl_rd_addr[21]) else $error("space select wrong");
   a_prog_align: assert property (fl_prog_start |->
      fl_op_addr[HOLD_BITS-1:0] == 0) else $error("program addr");
   a_erase_align: assert property (fl_erase_start |->
      fl_op_addr[5:0] == 6'h0) else $error("erase addr");
   a_op_cause: assert property ((fl_prog_start | fl_erase_start) |->
      $past(wr_done && paddr == 8'h00 && pwdata[2:1] == 2'b11))
      else $error("stray flash operation");
   a_hold_cause: assert property ($changed(fl_hold_data) |->
      $past(wr_done && paddr == 8'h14 && pwdata[1:0] == 2'b11) ||
      $past(fl_op_done)) else $error("holding data changed");
   a_done_set: assert property (fl_op_done |=> nvm_done_flag)
      else $error("done flag not set");
   a_done_clear: assert property ($fell(nvm_done_flag) |->
      $past(wr_done && paddr == 8'h18 && pwdata[1]))
      else $error("done flag lost");
endmodule // pmta_table_access_props

bind pmta_table_access pmta_table_access_props #(
   .HOLD_BITS(HOLD_BITS)) i_props (.*);

// File: bench/pmta_flash_model.sv
/* Flash array stand-in: answers byte reads after a short wait and ends
   program or erase after a longer one. Same clock as the block. */
`timescale 1ns/10ps
module pmta_flash_model (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // Byte read
   input wire        fl_rd_req,
   input wire [21:0] fl_rd_addr,
   output reg [7:0]  fl_rd_data,
   output reg        fl_rd_valid,
   // Program and erase
   input wire        fl_prog_start,
   input wire        fl_erase_start,
   output reg        fl_op_done
);
   reg [21:0] a_q;
   int        rc_q;
   int        oc_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_q <= 0;
         oc_q <= 0;
         a_q <= 22'h000000;
         fl_rd_valid <= 0;
         fl_op_done <= 0;
         fl_rd_data <= 8'h00;
      end else begin
         fl_rd_valid <= rc_q == 1;
         fl_op_done <= oc_q == 1;
         // Data only with valid; toggles otherwise
         fl_rd_data <= rc_q == 1 ? a_q[7:0] ^ a_q[15:8] ^
            {a_q[21], 2'h0, a_q[20:16]} : ~fl_rd_data;
         if (rc_q > 0) rc_q <= rc_q - 1;
         if (oc_q > 0) oc_q <= oc_q - 1;
         if (fl_rd_req) begin
            a_q <= fl_rd_addr;
            rc_q <= 1 + $urandom % 4;
         end
         if (fl_prog_start | fl_erase_start) oc_q <= 6 + $urandom % 20;
      end
   end
endmodule // pmta_flash_model

// File: bench/pmta_table_access_tb.sv
/* Self-checking bench for the table-access block.
   APB driven here; flash model on the far side. */
`timescale 1ns/10ps
module pmta_table_access_tb;
   reg          pclk, presetn, psel, penable, pwrite;
   reg  [7:0]   paddr;
   reg  [31:0]  pwdata;
   wire [31:0]  prdata;
   wire         pready, pslverr, fl_rd_req, fl_rd_valid, fl_prog_start;
   wire         fl_erase_start, fl_cfg_space, fl_op_done, nvm_done_flag;
   wire [21:0]  fl_rd_addr, fl_op_addr;
   wire [7:0]   fl_rd_data;
   wire [63:0]  fl_hold_data;
   int          error_cnt = 0;
   int          tests_run = 0;
   logic [63:0] q_rd[$], q_ad[$], q_hd[$], hd;
   logic [21:0] p;
   logic [31:0] b;
   pmta_table_access #(.HOLD_BITS(3)) i_dut (.*);
   pmta_flash_model i_fl (.*);

   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end
   task cmp(string n, logic [63:0] e, g);
      tests_run++;
      if (e !== g) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(bit w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask
   task wr(logic [7:0] a, logic [31:0] d);
      apb(1, a, d);
   endtask
   task rd(logic [7:0] a, logic [31:0] e);
      q_rd.push_back(e);
      apb(0, a, 0);
   endtask
   task ptr(bit w);
      for (int i = 0; i < 3; i++)
         if (w) wr(8'h08 + 8'(4 * i), (p >> 8 * i) & 32'hff);
         else rd(8'h08 + 8'(4 * i), (p >> 8 * i) & 32'hff);
   endtask
   function logic [21:0] stp(logic [21:0] a, bit dn);
      return {a[21], dn ? a[20:0] - 21'h1 : a[20:0] + 21'h1};
   endfunction
   task results;
      $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Result watcher
   always @(posedge pclk) begin
      if (fl_rd_req === 1'b1)
         cmp("fl_rd_addr", q_ad.pop_front(), 64'(fl_rd_addr));
      if ((fl_prog_start | fl_erase_start) === 1'b1) begin
         cmp("fl_op_addr", q_ad.pop_front(), 64'(fl_op_addr));
         cmp("fl_hold_data", q_hd.pop_front(), fl_hold_data);
      end
      if ((psel & penable & pready) === 1'b1)
         cmp("pslverr", 64'(paddr > 8'h18), 64'(pslverr));
      if ((psel & penable & pready & !pwrite) === 1'b1) begin
         #1;
         cmp("prdata", q_rd.pop_front(), 64'(prdata));
      end
   end
   initial begin
      #800000;
      error_cnt++;
      results;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = 0;
      b = $urandom(32'h23cf6396);
      repeat (16) @(posedge pclk);
      presetn <= 1;
      rd(8'h00, 0);
      for (int i = 0; i < 3; i++) begin
         b = $urandom;
         wr(8'h04, b);
         rd(8'h04, b & 32'hff);
         p = 22'($urandom);
         ptr(1);
         ptr(0);
      end
      rd(8'h1c, 0);
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         p = 22'($urandom);
         if (i < 4) p[20:0] = i == 2 ? 21'h0 : 21'h1fffff;
         ptr(1);
         if (i % 4 == 3) p = stp(p, 0);
         q_ad.push_back(p);
         wr(8'h14, 32'(i % 4 * 4 + 1));
         wr(8'h14, 0);
         rd(8'h04, p[7:0] ^ p[15:8] ^ {p[21], 2'h0, p[20:16]});
         if (i % 4 == 1 || i % 4 == 2) p = stp(p, i % 4 == 2);
         ptr(0);
      end
      $display("test table read done");
      p = 22'($urandom);
      ptr(1);
      hd = '1;
      for (int k = 0; k < 6; k++) begin
         b = $urandom;
         wr(8'h04, b);
         hd[8 * p[2:0] +: 8] = b[7:0];
         wr(8'h14, 32'h7);
         p = stp(p, 0);
      end
      ptr(0);
      wr(8'h00, 32'h82);
      rd(8'h00, 32'h80);
      wr(8'h00, 32'h84);
      q_ad.push_back({p[21:3], 3'h0});
      q_hd.push_back(hd);
      wr(8'h00, 32'h86);
      rd(8'h00, 32'h8e);
      wr(8'h14, 0);
      rd(8'h00, 32'h84);
      rd(8'h18, 2);
      wr(8'h18, 2);
      rd(8'h18, 0);
      q_ad.push_back({p[21:6], 6'h0});
      q_hd.push_back('1);
      wr(8'h00, 32'h96);
      wr(8'h14, 0);
      rd(8'h00, 32'h94);
      $display("test program erase done");
      repeat (2) @(posedge pclk);
      results;
   end
endmodule // pmta_table_access_tb
